/* alert_status_pkg.sv */
package alert_status_pkg;
   // Register map position and value after reset
   localparam int ADDR_W = 15;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 15'h0017;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   // Channels covered by this register
   localparam int NUM_CHAN = 4;
   localparam logic [3:0] FIRST_CHAN = 4'h8;
   // Field positions inside each channel's bit pair
   localparam int BITS_PER_CHAN = 2;
   localparam int LOW_BIT = 1;
   localparam int HIGH_BIT = 0;
   // Conversion result width
   localparam int RESULT_W = 16;
endpackage : alert_status_pkg

/* alert_flag_cell.sv */
`timescale 1ns/1ns
module alert_flag_cell #(
   parameter int DATA_W = alert_status_pkg::RESULT_W
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Conversion for this channel, already gated by detection enable
   input wire logic i_sample,
   input wire logic [DATA_W-1:0] i_result,
   // Channel limits and band
   input wire logic [DATA_W-1:0] i_upper,
   input wire logic [DATA_W-1:0] i_lower,
   input wire logic [DATA_W-1:0] i_band,
   input wire logic i_hyst_mode,
   // Clearing read
   input wire logic i_clear,
   // Flags
   output logic o_low_flag,
   output logic o_high_flag
);
   logic low_hit;
   logic high_hit;
   logic low_back;
   logic high_back;
   logic next_low;
   logic next_high;

   always_comb begin
      low_hit = i_sample && (i_result <= i_lower);
      high_hit = i_sample && (i_result >= i_upper);
      // One extra bit so the band never wraps around the limit
      low_back = i_sample && i_hyst_mode
         && ({1'b0, i_result} > ({1'b0, i_lower} + {1'b0, i_band}));
      high_back = i_sample && i_hyst_mode
         && (({1'b0, i_result} + {1'b0, i_band}) < {1'b0, i_upper});
      next_low = o_low_flag;
      next_high = o_high_flag;
      if (i_clear || low_back) begin
         next_low = 1'b0;
      end
      if (i_clear || high_back) begin
         next_high = 1'b0;
      end
      // Set after clear so a crossing during a read survives
      if (low_hit) begin
         next_low = 1'b1;
      end
      if (high_hit) begin
         next_high = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_low_flag <= alert_status_pkg::STATUS_RESET[alert_status_pkg::LOW_BIT];
         o_high_flag <= alert_status_pkg::STATUS_RESET[alert_status_pkg::HIGH_BIT];
      end else begin
         o_low_flag <= next_low;
         o_high_flag <= next_high;
      end
   end
endmodule : alert_flag_cell

/* threshold_alert_status_ch8_11.sv */
`timescale 1ns/1ns
module threshold_alert_status_ch8_11 #(
   parameter int DATA_W = alert_status_pkg::RESULT_W
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Conversion results
   input wire logic i_conv_valid,
   input wire logic [3:0] i_conv_chan,
   input wire logic [DATA_W-1:0] i_conv_result,
   // Per-channel settings, channel 8 in the lowest slice, and i_hyst_mode shared by all channels
   input wire logic [alert_status_pkg::NUM_CHAN*DATA_W-1:0] i_upper_limit,
   input wire logic [alert_status_pkg::NUM_CHAN*DATA_W-1:0] i_lower_limit,
   input wire logic [alert_status_pkg::NUM_CHAN*DATA_W-1:0] i_band_width,
   input wire logic [alert_status_pkg::NUM_CHAN-1:0] i_detect_enable,
   input wire logic i_hyst_mode,
   // Register read port
   input wire logic i_reg_rd,
   input wire logic [alert_status_pkg::ADDR_W-1:0] i_reg_addr,
   output logic [7:0] o_reg_rd_data,
   output logic o_reg_rd_valid,
   // Live flags for alert logic
   output logic [7:0] o_alert_flags
);
   localparam int NC = alert_status_pkg::NUM_CHAN;

   if (DATA_W < 2 || DATA_W > 32) begin : g_bad_width
      $error("DATA_W must lie between 2 and 32");
   end

   logic rd_hit;
   logic [NC-1:0] sample;
   logic [7:0] flags;
   logic [7:0] next_rd_data;
   logic next_rd_valid;

   // A read of this register is also the clear strobe
   assign rd_hit = i_reg_rd && (i_reg_addr == alert_status_pkg::STATUS_ADDR);

   for (genvar k = 0; k < NC; k++) begin : g_chan
      logic [3:0] chan_id;
      assign chan_id = alert_status_pkg::FIRST_CHAN + 4'(k);
      assign sample[k] = i_conv_valid && (i_conv_chan == chan_id) && i_detect_enable[k];

      alert_flag_cell #(
         .DATA_W(DATA_W)
      ) u_cell (
         .i_clk(i_clk),
         .i_rst(i_rst),
         .i_sample(sample[k]),
         .i_result(i_conv_result),
         .i_upper(i_upper_limit[k*DATA_W +: DATA_W]),
         .i_lower(i_lower_limit[k*DATA_W +: DATA_W]),
         .i_band(i_band_width[k*DATA_W +: DATA_W]),
         .i_hyst_mode(i_hyst_mode),
         .i_clear(rd_hit),
         .o_low_flag(flags[alert_status_pkg::BITS_PER_CHAN*k + alert_status_pkg::LOW_BIT]),
         .o_high_flag(flags[alert_status_pkg::BITS_PER_CHAN*k + alert_status_pkg::HIGH_BIT])
      );
   end

   assign o_alert_flags = flags;

   // Unmapped addresses answer zero and clear nothing
   always_comb begin
      next_rd_valid = i_reg_rd;
      next_rd_data = 8'h00;
      if (rd_hit) begin
         next_rd_data = flags;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_reg_rd_data <= alert_status_pkg::STATUS_RESET;
         o_reg_rd_valid <= 1'b0;
      end else begin
         o_reg_rd_data <= next_rd_data;
         o_reg_rd_valid <= next_rd_valid;
      end
   end

   // Checks of the whole register
   a_reset_zero: assert property (@(posedge i_clk)
      i_rst |=> (flags == 8'h00 && o_reg_rd_data == 8'h00 && !o_reg_rd_valid))
      else $error("Flags or read data not zero after reset");

   a_read_returns: assert property (@(posedge i_clk) disable iff (i_rst)
      rd_hit |=> (o_reg_rd_valid && o_reg_rd_data == $past(flags)))
      else $error("Read did not return the flags held at the read");

   a_read_clears: assert property (@(posedge i_clk) disable iff (i_rst)
      (rd_hit && !i_conv_valid) |=> (flags == 8'h00))
      else $error("Read without a conversion left a flag set");

   a_unmapped_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_reg_rd && !rd_hit && !i_conv_valid)
         |=> (o_reg_rd_data == 8'h00 && flags == $past(flags)))
      else $error("Unmapped read returned data or cleared flags");

   a_sticky_idle: assert property (@(posedge i_clk) disable iff (i_rst)
      (!i_reg_rd && !i_conv_valid) [*2] |=> (flags == $past(flags, 2)))
      else $error("Flags changed with no read and no conversion");

   // Read port answers every request, hit or not, one cycle later
   a_valid_follows: assert property (@(posedge i_clk) disable iff (i_rst)
      i_reg_rd |=> o_reg_rd_valid)
      else $error("Read request got no valid one cycle later");

   a_valid_one_cycle: assert property (@(posedge i_clk) disable iff (i_rst)
      !i_reg_rd |=> (!o_reg_rd_valid && o_reg_rd_data == 8'h00))
      else $error("Read valid or data stood without a request");

   a_unmapped_valid: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_reg_rd && !rd_hit) |=> (o_reg_rd_valid && o_reg_rd_data == 8'h00))
      else $error("Unmapped read gave no valid or returned data");

   // Results for channels outside this register must leave it alone
   a_other_chan_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_conv_valid && !i_reg_rd && (i_conv_chan < alert_status_pkg::FIRST_CHAN
         || i_conv_chan > alert_status_pkg::FIRST_CHAN + 4'(NC - 1)))
         |=> (flags == $past(flags)))
      else $error("Result for another channel changed a flag");

   // Checks per channel
   for (genvar k = 0; k < NC; k++) begin : g_check
      localparam int LB = alert_status_pkg::BITS_PER_CHAN*k + alert_status_pkg::LOW_BIT;
      localparam int HB = alert_status_pkg::BITS_PER_CHAN*k + alert_status_pkg::HIGH_BIT;
      logic [DATA_W-1:0] up;
      logic [DATA_W-1:0] lo;
      logic [DATA_W-1:0] bw;
      logic on_chan;
      assign up = i_upper_limit[k*DATA_W +: DATA_W];
      assign lo = i_lower_limit[k*DATA_W +: DATA_W];
      assign bw = i_band_width[k*DATA_W +: DATA_W];
      assign on_chan = i_conv_valid
         && (i_conv_chan == alert_status_pkg::FIRST_CHAN + 4'(k));

      a_low_sets: assert property (@(posedge i_clk) disable iff (i_rst)
         (on_chan && i_detect_enable[k] && i_conv_result <= lo) |=> flags[LB])
         else $error("Low-limit crossing did not set its flag");

      a_high_sets: assert property (@(posedge i_clk) disable iff (i_rst)
         (on_chan && i_detect_enable[k] && i_conv_result >= up) |=> flags[HB])
         else $error("High-limit crossing did not set its flag");

      a_disabled_no_set: assert property (@(posedge i_clk) disable iff (i_rst)
         (on_chan && !i_detect_enable[k] && !flags[LB] && !flags[HB])
            |=> (!flags[LB] && !flags[HB]))
         else $error("Disabled channel set a flag");

      a_set_beats_clear: assert property (@(posedge i_clk) disable iff (i_rst)
         (rd_hit && on_chan && i_detect_enable[k] && i_conv_result <= lo)
            |=> (flags[LB] && o_reg_rd_valid))
         else $error("Crossing during a read was lost");

      a_band_clears_high: assert property (@(posedge i_clk) disable iff (i_rst)
         (i_hyst_mode && on_chan && i_detect_enable[k] && flags[HB]
            && ({1'b0, i_conv_result} + {1'b0, bw}) < {1'b0, up}) |=> !flags[HB])
         else $error("In-band result did not clear the high flag");

      a_band_clears_low: assert property (@(posedge i_clk) disable iff (i_rst)
         (i_hyst_mode && on_chan && i_detect_enable[k] && flags[LB]
            && {1'b0, i_conv_result} > ({1'b0, lo} + {1'b0, bw})) |=> !flags[LB])
         else $error("In-band result did not clear the low flag");

      a_no_band_sticky: assert property (@(posedge i_clk) disable iff (i_rst)
         (!i_hyst_mode && !i_reg_rd && flags[HB]) |=> flags[HB])
         else $error("High flag cleared without a read in sticky mode");

      a_no_band_sticky_low: assert property (@(posedge i_clk) disable iff (i_rst)
         (!i_hyst_mode && !i_reg_rd && flags[LB]) |=> flags[LB])
         else $error("Low flag cleared without a read in sticky mode");

      a_high_beats_clear: assert property (@(posedge i_clk) disable iff (i_rst)
         (rd_hit && on_chan && i_detect_enable[k] && i_conv_result >= up) |=> flags[HB])
         else $error("High crossing during a read was lost");

      // A flag moves only for its own causes
      a_low_no_cause: assert property (@(posedge i_clk) disable iff (i_rst)
         (!flags[LB] && !(on_chan && i_detect_enable[k] && i_conv_result <= lo))
            |=> !flags[LB])
         else $error("Low flag set with no crossing");

      a_high_no_cause: assert property (@(posedge i_clk) disable iff (i_rst)
         (!flags[HB] && !(on_chan && i_detect_enable[k] && i_conv_result >= up))
            |=> !flags[HB])
         else $error("High flag set with no crossing");

      a_low_holds: assert property (@(posedge i_clk) disable iff (i_rst)
         (flags[LB] && !rd_hit && !(i_hyst_mode && on_chan && i_detect_enable[k]))
            |=> flags[LB])
         else $error("Low flag cleared with no read and no in-band result");

      a_high_holds: assert property (@(posedge i_clk) disable iff (i_rst)
         (flags[HB] && !rd_hit && !(i_hyst_mode && on_chan && i_detect_enable[k]))
            |=> flags[HB])
         else $error("High flag cleared with no read and no in-band result");

      // Band edges are exclusive, so a result on the edge keeps the flag
      a_edge_keeps_low: assert property (@(posedge i_clk) disable iff (i_rst)
         (flags[LB] && !rd_hit && on_chan
            && {1'b0, i_conv_result} <= ({1'b0, lo} + {1'b0, bw})) |=> flags[LB])
         else $error("Low flag cleared by a result outside its band");

      a_edge_keeps_high: assert property (@(posedge i_clk) disable iff (i_rst)
         (flags[HB] && !rd_hit && on_chan
            && ({1'b0, i_conv_result} + {1'b0, bw}) >= {1'b0, up}) |=> flags[HB])
         else $error("High flag cleared by a result outside its band");

      // Detection off freezes the pair, only a read may clear it
      a_disabled_frozen: assert property (@(posedge i_clk) disable iff (i_rst)
         (on_chan && !i_detect_enable[k] && !rd_hit)
            |=> (flags[LB] == $past(flags[LB]) && flags[HB] == $past(flags[HB])))
         else $error("Disabled channel changed a flag");
   end
endmodule : threshold_alert_status_ch8_11

/* host_reader.sv */
`timescale 1ns/1ns
module host_reader (
   // Clock
   input wire logic i_clk,
   // Request from the sequence
   input wire logic i_go,
   input wire logic [14:0] i_addr,
   // Device read port
   output logic o_rd,
   output logic [14:0] o_addr,
   input wire logic [7:0] i_data,
   input wire logic i_valid,
   // Captured answer
   output logic [7:0] o_word,
   output logic o_got
);
   // Idle address is inverted so a stale value never passes for a request
   assign o_rd = i_go;
   assign o_addr = i_go ? i_addr : ~i_addr;
   always_ff @(posedge i_clk) begin
      o_got <= i_valid;
      if (i_valid) begin
         o_word <= i_data;
      end
   end
endmodule : host_reader

/* threshold_alert_status_ch8_11_test.sv */
`timescale 1ns/1ns
module threshold_alert_status_ch8_11_test;
   localparam logic [14:0] HIT = alert_status_pkg::STATUS_ADDR;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_conv_valid = 1'b0;
   logic [3:0] i_conv_chan = 4'h0;
   logic [15:0] i_conv_result = 16'h0000;
   logic [63:0] i_upper_limit, i_lower_limit, i_band_width;
   logic [3:0] i_detect_enable = 4'hf;
   logic i_hyst_mode = 1'b0;
   logic go = 1'b0;
   logic [14:0] go_addr = 15'h0000;
   logic rd, valid, got;
   logic [14:0] addr;
   logic [7:0] rdata, flags, word, exp;
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   always #4 i_clk = ~i_clk;
   threshold_alert_status_ch8_11 uut (.i_clk(i_clk), .i_rst(i_rst), .i_conv_valid(i_conv_valid),
      .i_conv_chan(i_conv_chan), .i_conv_result(i_conv_result), .i_upper_limit(i_upper_limit),
      .i_lower_limit(i_lower_limit), .i_band_width(i_band_width), .i_hyst_mode(i_hyst_mode),
      .i_detect_enable(i_detect_enable), .i_reg_rd(rd), .i_reg_addr(addr),
      .o_reg_rd_data(rdata), .o_reg_rd_valid(valid), .o_alert_flags(flags));
   host_reader host (.i_clk(i_clk), .i_go(go), .i_addr(go_addr), .o_rd(rd), .o_addr(addr),
      .i_data(rdata), .i_valid(valid), .o_word(word), .o_got(got));
   function automatic logic [15:0] lo(input int k);
      return 16'h4000 + 16'(k);
   endfunction : lo
   function automatic logic [15:0] hi(input int k);
      return 16'hc000 + 16'(k);
   endfunction : hi
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      samples_checked++;
      if (seen !== want) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, want);
      end
   endtask : check
   // One idle cycle after each pulse, so two calls never touch the strobe in one step
   task automatic conv(input logic [3:0] ch, input logic [15:0] val);
      i_conv_valid = 1'b1;
      i_conv_chan = ch;
      i_conv_result = val;
      @(negedge i_clk);
      i_conv_valid = 1'b0;
      @(negedge i_clk);
   endtask : conv
   task automatic rd_reg(input logic [14:0] a, input logic [7:0] want);
      go = 1'b1;
      go_addr = a;
      @(negedge i_clk);
      go = 1'b0;
      i_conv_valid = 1'b0;
      check({7'h00, valid}, 8'h01);
      @(negedge i_clk);
      check({7'h00, valid}, 8'h00);
      check({7'h00, got}, 8'h01);
      check(rdata, 8'h00);
      check(word, want);
   endtask : rd_reg
   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   initial begin
      // Distinct limits per channel expose a wrong slice
      for (int k = 0; k < 4; k++) begin
         i_upper_limit[k*16 +: 16] = hi(k);
         i_lower_limit[k*16 +: 16] = lo(k);
         i_band_width[k*16 +: 16] = 16'h0100;
      end
      repeat (10) @(negedge i_clk);
      i_rst = 1'b0;
      check(flags, 8'h00);
      rd_reg(HIT, 8'h00);
      exp = 8'h00;
      for (int k = 0; k < 4; k++) begin
         conv(4'h8 + 4'(k), lo(k) + 16'h0001);
         conv(4'h8 + 4'(k), hi(k) - 16'h0001);
         check(flags, exp);
         conv(4'h8 + 4'(k), lo(k));
         check(flags, exp | (8'h02 << (2 * k)));
         conv(4'h8 + 4'(k), hi(k));
         exp = exp | (8'h03 << (2 * k));
         check(flags, exp);
      end
      rd_reg(HIT, 8'hff);
      check(flags, 8'h00);
      rd_reg(HIT, 8'h00);
      conv(4'h7, 16'h0000);
      conv(4'hc, 16'hffff);
      conv(4'h8, 16'h0000);
      rd_reg(15'h0016, 8'h00);
      check(flags, 8'h02);
      i_detect_enable = 4'hd;
      conv(4'h9, 16'h0000);
      conv(4'h8, 16'h8000);
      check(flags, 8'h02);
      // Disabled channel ignores an in-band result too
      i_detect_enable = 4'he;
      i_hyst_mode = 1'b1;
      conv(4'h8, 16'h8000);
      check(flags, 8'h02);
      i_detect_enable = 4'hf;
      i_hyst_mode = 1'b1;
      conv(4'h8, lo(0) + 16'h0100);
      check(flags, 8'h02);
      conv(4'h8, lo(0) + 16'h0101);
      check(flags, 8'h00);
      conv(4'h8, hi(0));
      conv(4'h8, hi(0) - 16'h0100);
      check(flags, 8'h01);
      conv(4'h8, hi(0) - 16'h0101);
      check(flags, 8'h00);
      i_hyst_mode = 1'b0;
      conv(4'h9, lo(1));
      i_conv_valid = 1'b1;
      i_conv_chan = 4'ha;
      i_conv_result = hi(2);
      rd_reg(HIT, 8'h08);
      check(flags, 8'h10);
      i_conv_valid = 1'b1;
      i_conv_chan = 4'hb;
      i_conv_result = 16'h0000;
      rd_reg(HIT, 8'h10);
      check(flags, 8'h80);
      // Reset in mid-run must drop a standing flag
      i_rst = 1'b1;
      @(negedge i_clk);
      i_rst = 1'b0;
      check(flags, 8'h00);
      rd_reg(HIT, 8'h00);
      tally_and_finish();
   end
endmodule : threshold_alert_status_ch8_11_test
